// ==== hw/flash_host_pkg.sv ====
// constants and types shared by the flash suspend/bypass host controller
package flash_host_pkg;
    // pin and bus geometry
    localparam int ADDR_W   = 23;
    localparam int DATA_W   = 32;
    localparam int SECT_LSB = 16;
    localparam int SECTORS  = 128;
    localparam int CNT_W    = 8;

    // pin timing, figures in ns, counts rounded up to whole cycles
    localparam int CLK_PERIOD_NS = 8;
    localparam int T_SETUP_NS    = 10;
    localparam int T_WP_NS       = 50;
    localparam int T_WPH_NS      = 30;
    localparam int T_ACC_NS      = 120;
    localparam int SYNC_CYC      = 2;
    localparam logic [CNT_W-1:0] SETUP_CYC =
        CNT_W'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] WP_CYC =
        CNT_W'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] WPH_CYC =
        CNT_W'((T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RD_CYC =
        CNT_W'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_CYC);
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

    // accelerated program uses allowed per sector
    localparam logic [3:0] ACC_LIMIT = 4'hA;

    // flash command cycles
    localparam logic [ADDR_W-1:0] UNLOCK1_ADDR  = 23'h00_0555;
    localparam logic [ADDR_W-1:0] UNLOCK2_ADDR  = 23'h00_02AA;
    localparam logic [DATA_W-1:0] DAT_UNLOCK1   = 32'h0000_00AA;
    localparam logic [DATA_W-1:0] DAT_UNLOCK2   = 32'h0000_0055;
    localparam logic [DATA_W-1:0] DAT_BYP_ENTER = 32'h0000_0020;
    localparam logic [DATA_W-1:0] DAT_PROGRAM   = 32'h0000_00A0;
    localparam logic [DATA_W-1:0] DAT_BYP_EXIT1 = 32'h0000_0090;
    localparam logic [DATA_W-1:0] DAT_BYP_EXIT2 = 32'h0000_0000;
    localparam logic [DATA_W-1:0] DAT_RESET     = 32'h0000_00F0;
    localparam logic [DATA_W-1:0] DAT_ERS_SUSP  = 32'h0000_00B0;
    localparam logic [DATA_W-1:0] DAT_ERS_RES   = 32'h0000_0030;
    localparam logic [DATA_W-1:0] DAT_PRG_SUSP  = 32'h0000_00B0;
    localparam logic [DATA_W-1:0] DAT_PRG_RES   = 32'h0000_0030;
    localparam logic [DATA_W-1:0] DAT_NONE      = 32'h0000_0000;

    // operation codes written to the command register
    localparam logic [3:0] OP_READ      = 4'h0;
    localparam logic [3:0] OP_WRITE     = 4'h1;
    localparam logic [3:0] OP_ERS_SUSP  = 4'h2;
    localparam logic [3:0] OP_ERS_RES   = 4'h3;
    localparam logic [3:0] OP_PRG_SUSP  = 4'h4;
    localparam logic [3:0] OP_PRG_RES   = 4'h5;
    localparam logic [3:0] OP_BYP_ENTER = 4'h6;
    localparam logic [3:0] OP_BYP_PROG  = 4'h7;
    localparam logic [3:0] OP_BYP_EXIT  = 4'h8;
    localparam logic [3:0] OP_ABORT_RST = 4'h9;
    localparam logic [3:0] OP_POLL      = 4'hA;

    // register offsets and fields
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_CMD    = 12'h004;
    localparam logic [11:0] REG_ADDR   = 12'h008;
    localparam logic [11:0] REG_WDATA  = 12'h00C;
    localparam logic [11:0] REG_STATUS = 12'h010;
    localparam logic [11:0] REG_RDATA  = 12'h014;
    localparam int CTRL_ACC_BIT = 0;
    localparam int CTRL_RST_BIT = 1;
    localparam int CMD_EXP_BIT  = 8;
    localparam int POLL_BIT     = 7;
    localparam int TOGGLE1_BIT  = 6;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_RECOVER} phase_e;
    typedef enum logic [1:0] {SQ_IDLE, SQ_ISSUE, SQ_WAIT} seq_e;
endpackage

// ==== hw/flash_bus_cycle.sv ====
// one asynchronous flash bus cycle, write or read, on the pins
`timescale 1ns/100ps
module flash_bus_cycle
    import flash_host_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // request and answer
    input  wire logic              start,
    input  wire logic              wr,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    output logic                   done,
    output logic      [DATA_W-1:0] rdata,
    // flash pins
    output logic      [ADDR_W-1:0] flash_addr,
    output logic      [DATA_W-1:0] flash_dq_o,
    output logic                   flash_dq_oe,
    input  wire logic [DATA_W-1:0] flash_dq_i,
    output logic                   flash_ce_n,
    output logic                   flash_oe_n,
    output logic                   flash_we_n
);
    phase_e            phase_q;
    logic [CNT_W-1:0]  cnt_q;
    logic              wr_q;
    logic [DATA_W-1:0] dq_s1_q;
    logic [DATA_W-1:0] dq_s2_q;
    wire               last = (cnt_q == CNT_ONE);

    // two-flop capture of the data pins
    always_ff @(posedge core_clk) begin
        dq_s1_q <= flash_dq_i;
        dq_s2_q <= dq_s1_q;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase_q     <= PH_IDLE;
            cnt_q       <= '0;
            wr_q        <= 1'b0;
            done        <= 1'b0;
            rdata       <= '0;
            flash_addr  <= '0;
            flash_dq_o  <= '0;
            flash_dq_oe <= 1'b0;
            flash_ce_n  <= 1'b1;
            flash_oe_n  <= 1'b1;
            flash_we_n  <= 1'b1;
        end else begin
            done <= 1'b0;
            unique case (phase_q)
                PH_IDLE: if (start) begin
                    flash_addr  <= addr;
                    flash_dq_o  <= wdata;
                    flash_dq_oe <= wr;
                    flash_ce_n  <= 1'b0;
                    wr_q        <= wr;
                    cnt_q       <= SETUP_CYC;
                    phase_q     <= PH_SETUP;
                end
                PH_SETUP: if (last) begin
                    flash_we_n <= ~wr_q;
                    flash_oe_n <= wr_q;
                    cnt_q      <= wr_q ? WP_CYC : RD_CYC;
                    phase_q    <= PH_STROBE;
                end else begin
                    cnt_q <= cnt_q - CNT_ONE;
                end
                // strobe rises between reads so the toggle bits can advance
                PH_STROBE: if (last) begin
                    flash_we_n <= 1'b1;
                    flash_oe_n <= 1'b1;
                    if (!wr_q) begin
                        rdata <= dq_s2_q;
                    end
                    cnt_q   <= WPH_CYC;
                    phase_q <= PH_RECOVER;
                end else begin
                    cnt_q <= cnt_q - CNT_ONE;
                end
                PH_RECOVER: if (last) begin
                    flash_ce_n  <= 1'b1;
                    flash_dq_oe <= 1'b0;
                    done        <= 1'b1;
                    phase_q     <= PH_IDLE;
                end else begin
                    cnt_q <= cnt_q - CNT_ONE;
                end
            endcase
        end
    end
endmodule

// ==== hw/flash_suspend_bypass_status.sv ====
// host controller: suspend, resume, unlock bypass and status polling of a nor flash
`timescale 1ns/100ps
// Notes on behaviour
// - erase suspend carries the sector address
// - erase resume goes to the address register
// - program resume leaves program suspend
// - at most ten accelerated programs per sector
// - abort reset under acceleration: three cycles
// - bypass exit: 90h at sector, then 00h
module flash_suspend_bypass_status
    import flash_host_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // axi4-lite slave
    input  wire logic [11:0]       s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic      [1:0]        s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [11:0]       s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic      [31:0]       s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // flash pins
    output logic      [ADDR_W-1:0] flash_addr,
    output logic      [DATA_W-1:0] flash_dq_o,
    output logic                   flash_dq_oe,
    input  wire logic [DATA_W-1:0] flash_dq_i,
    output logic                   flash_ce_n,
    output logic                   flash_oe_n,
    output logic                   flash_we_n,
    output logic                   flash_reset_n,
    output logic                   protect_accelerate_pin_hv
);
    // last step index of each operation
    function automatic logic [1:0] last_step(input logic [3:0] op);
        if (op == OP_BYP_ENTER || op == OP_ABORT_RST) return 2'd2;
        if (op == OP_BYP_PROG || op == OP_BYP_EXIT) return 2'd1;
        return 2'd0;
    endfunction

    // {write, address, data} of one step
    function automatic logic [ADDR_W+DATA_W:0] step_of(input logic [3:0] op,
        input logic [1:0] idx, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [ADDR_W-1:0] ua;
        logic [DATA_W-1:0] ud;
        ua = (idx == 2'd1) ? UNLOCK2_ADDR : UNLOCK1_ADDR;
        ud = (idx == 2'd1) ? DAT_UNLOCK2 : DAT_UNLOCK1;
        unique case (op)
            OP_READ, OP_POLL: return {1'b0, a, DAT_NONE};
            OP_WRITE:         return {1'b1, a, d};
            OP_ERS_SUSP:      return {1'b1, a, DAT_ERS_SUSP};
            OP_ERS_RES:       return {1'b1, a, DAT_ERS_RES};
            OP_PRG_SUSP:      return {1'b1, a, DAT_PRG_SUSP};
            OP_PRG_RES:       return {1'b1, a, DAT_PRG_RES};
            OP_BYP_ENTER:     return {1'b1, ua, (idx == 2'd2) ? DAT_BYP_ENTER : ud};
            OP_BYP_PROG:      return (idx == 2'd0) ? {1'b1, UNLOCK1_ADDR, DAT_PROGRAM}
                                                   : {1'b1, a, d};
            OP_BYP_EXIT:      return {1'b1, a, (idx == 2'd0) ? DAT_BYP_EXIT1 : DAT_BYP_EXIT2};
            // abort reset sends all three cycles
            OP_ABORT_RST:     return {1'b1, ua, (idx == 2'd2) ? DAT_RESET : ud};
            default:          return {1'b0, a, DAT_NONE};
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) m[i*8 +: 8] = nw[i*8 +: 8];
        end
        return m;
    endfunction

    // bus slave state
    logic              aw_hold_q;
    logic              w_hold_q;
    logic [11:0]       awaddr_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    // software registers
    logic [1:0]        ctrl_q;
    logic [ADDR_W-1:0] reg_addr_q;
    logic [DATA_W-1:0] reg_wdata_q;
    logic [DATA_W-1:0] reg_rdata_q;
    // sequencer
    seq_e              seq_q;
    logic [3:0]        op_q;
    logic [1:0]        step_q;
    logic              exp_q;
    logic              start_q;
    logic              cyc_wr_q;
    logic [ADDR_W-1:0] cyc_addr_q;
    logic [DATA_W-1:0] cyc_data_q;
    logic              done_flag_q;
    logic              refused_q;
    logic              bypass_q;
    logic              ers_susp_q;
    logic              prg_susp_q;
    logic              prev_tog_q;
    logic              toggling_q;
    logic [3:0]        acc_uses_q [SECTORS];
    logic              cyc_done;
    logic [DATA_W-1:0] cyc_rdata;

    // write decode
    wire        wr_fire   = aw_hold_q && w_hold_q && !s_axi_bvalid;
    wire        wr_known  = awaddr_q inside {REG_CTRL, REG_CMD, REG_ADDR, REG_WDATA};
    wire [31:0] w_ctrl    = merge({30'd0, ctrl_q}, w_data_q, w_strb_q);
    wire [31:0] w_addr    = merge({{(32-ADDR_W){1'b0}}, reg_addr_q}, w_data_q, w_strb_q);
    wire        cmd_go    = wr_fire && awaddr_q == REG_CMD && |w_strb_q;
    wire [3:0]  cmd_op    = w_data_q[3:0];
    wire        acc_on    = protect_accelerate_pin_hv;
    wire        in_bypass = bypass_q || acc_on;
    wire [6:0]  sect      = reg_addr_q[ADDR_W-1:SECT_LSB];
    // acceleration budget per sector
    wire        acc_spent = acc_on && acc_uses_q[sect] >= ACC_LIMIT;
    wire        refuse    = seq_q != SQ_IDLE || cmd_op > OP_POLL
                            || (cmd_op == OP_BYP_PROG && (!in_bypass || acc_spent))
                            || (cmd_op == OP_BYP_EXIT && (!bypass_q || acc_on));
    wire        busy      = seq_q != SQ_IDLE;
    wire        step_end  = seq_q == SQ_WAIT && cyc_done;
    wire        poll_hit  = cyc_rdata[POLL_BIT] == exp_q;
    wire        op_end    = step_end && (op_q == OP_POLL ? poll_hit : step_q == last_step(op_q));
    wire [ADDR_W+DATA_W:0] step_word = step_of(op_q, step_q, reg_addr_q, reg_wdata_q);

    // read decode
    wire [31:0] status_word = {24'd0, acc_on, toggling_q, prg_susp_q, ers_susp_q,
                               in_bypass, refused_q, done_flag_q, busy};
    wire        rd_known = s_axi_araddr inside {REG_CTRL, REG_CMD, REG_ADDR, REG_WDATA,
                                                REG_STATUS, REG_RDATA};
    wire [31:0] rd_word  = s_axi_araddr == REG_CTRL   ? {30'd0, ctrl_q}
                         : s_axi_araddr == REG_ADDR   ? {{(32-ADDR_W){1'b0}}, reg_addr_q}
                         : s_axi_araddr == REG_WDATA  ? reg_wdata_q
                         : s_axi_araddr == REG_STATUS ? status_word
                         : s_axi_araddr == REG_RDATA  ? reg_rdata_q : 32'h0000_0000;

    // axi4-lite write and read channels
    always_ff @(posedge core_clk) begin
        if (rst) begin
            {aw_hold_q, w_hold_q, s_axi_bvalid, s_axi_rvalid} <= 4'h0;
            {s_axi_awready, s_axi_wready, s_axi_arready} <= 3'h7;
            awaddr_q    <= '0;
            w_data_q    <= '0;
            w_strb_q    <= '0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q     <= 1'b1;
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q     <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                {aw_hold_q, w_hold_q} <= 2'b00;
                s_axi_bvalid          <= 1'b1;
                s_axi_bresp           <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid                  <= 1'b0;
                {s_axi_awready, s_axi_wready} <= 2'b11;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= rd_known ? RESP_OKAY : RESP_SLVERR;
                s_axi_rvalid  <= 1'b1;
                s_axi_arready <= 1'b0;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // software registers and pin levels
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_q                    <= '0;
            reg_addr_q                <= '0;
            reg_wdata_q               <= '0;
            flash_reset_n             <= 1'b0;
            protect_accelerate_pin_hv <= 1'b0;
        end else begin
            if (wr_fire && awaddr_q == REG_CTRL) ctrl_q <= w_ctrl[1:0];
            if (wr_fire && awaddr_q == REG_ADDR) reg_addr_q <= w_addr[ADDR_W-1:0];
            if (wr_fire && awaddr_q == REG_WDATA) begin
                reg_wdata_q <= merge(reg_wdata_q, w_data_q, w_strb_q);
            end
            flash_reset_n <= ~ctrl_q[CTRL_RST_BIT];
            if (!busy) protect_accelerate_pin_hv <= ctrl_q[CTRL_ACC_BIT];
        end
    end

    // operation sequencer
    always_ff @(posedge core_clk) begin
        if (rst) begin
            seq_q      <= SQ_IDLE;
            {op_q, step_q, exp_q, start_q} <= '0;
            cyc_wr_q   <= 1'b0;
            cyc_addr_q <= '0;
            cyc_data_q <= '0;
        end else begin
            start_q <= 1'b0;
            unique case (seq_q)
                SQ_IDLE: if (cmd_go && !refuse) begin
                    op_q   <= cmd_op;
                    exp_q  <= w_data_q[CMD_EXP_BIT];
                    step_q <= 2'd0;
                    seq_q  <= SQ_ISSUE;
                end
                SQ_ISSUE: begin
                    start_q                              <= 1'b1;
                    {cyc_wr_q, cyc_addr_q, cyc_data_q}   <= step_word;
                    seq_q                                <= SQ_WAIT;
                end
                SQ_WAIT: if (cyc_done) begin
                    seq_q <= op_end ? SQ_IDLE : SQ_ISSUE;
                    if (!op_end && op_q != OP_POLL) step_q <= step_q + 2'd1;
                end
                default: seq_q <= SQ_IDLE;
            endcase
        end
    end

    // flags, read data, mode tracking; a set wins over a clear
    always_ff @(posedge core_clk) begin
        if (rst || !flash_reset_n) begin
            {done_flag_q, refused_q, bypass_q, ers_susp_q, prg_susp_q} <= '0;
            {prev_tog_q, toggling_q} <= 2'b00;
            reg_rdata_q <= '0;
            for (int i = 0; i < SECTORS; i++) acc_uses_q[i] <= '0;
        end else begin
            if (cmd_go) refused_q <= refuse;
            if (cmd_go && !refuse) done_flag_q <= 1'b0;
            if (op_end) done_flag_q <= 1'b1;
            if (step_end && !cyc_wr_q) begin
                reg_rdata_q <= cyc_rdata;
                prev_tog_q  <= cyc_rdata[TOGGLE1_BIT];
                toggling_q  <= cyc_rdata[TOGGLE1_BIT] ^ prev_tog_q;
            end
            if (op_end) begin
                if (op_q == OP_BYP_ENTER) bypass_q <= 1'b1;
                if (op_q == OP_BYP_EXIT) bypass_q <= 1'b0;
                if (op_q == OP_ERS_SUSP) ers_susp_q <= 1'b1;
                if (op_q == OP_ERS_RES) ers_susp_q <= 1'b0;
                if (op_q == OP_PRG_SUSP) prg_susp_q <= 1'b1;
                if (op_q == OP_PRG_RES) prg_susp_q <= 1'b0;
                if (op_q == OP_BYP_PROG && acc_on) acc_uses_q[sect] <= acc_uses_q[sect] + 4'h1;
            end
        end
    end

    flash_bus_cycle u_cycle (
        .core_clk    (core_clk),
        .rst         (rst),
        .start       (start_q),
        .wr          (cyc_wr_q),
        .addr        (cyc_addr_q),
        .wdata       (cyc_data_q),
        .done        (cyc_done),
        .rdata       (cyc_rdata),
        .flash_addr  (flash_addr),
        .flash_dq_o  (flash_dq_o),
        .flash_dq_oe (flash_dq_oe),
        .flash_dq_i  (flash_dq_i),
        .flash_ce_n  (flash_ce_n),
        .flash_oe_n  (flash_oe_n),
        .flash_we_n  (flash_we_n)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_abort_end;
        op_q == OP_ABORT_RST && step_end;
    endsequence
    sequence s_exit_first;
        op_q == OP_BYP_EXIT && step_end && step_q == 2'd0;
    endsequence

    a_ers_susp_addr: assert property (
        start_q && op_q == OP_ERS_SUSP |-> cyc_addr_q[ADDR_W-1:SECT_LSB] == sect)
        else $error("erase suspend not at the selected sector");
    a_ers_resume_cmd: assert property (
        start_q && op_q == OP_ERS_RES |-> cyc_wr_q && cyc_data_q == DAT_ERS_RES
            && cyc_addr_q == reg_addr_q)
        else $error("erase resume cycle wrong");
    a_prg_resume_clear: assert property (
        op_end && op_q == OP_PRG_RES |=> !prg_susp_q && done_flag_q)
        else $error("program resume did not leave suspend");
    a_acc_use_limit: assert property (
        start_q && op_q == OP_BYP_PROG && step_q == 2'd1 && acc_on |-> acc_uses_q[sect] < ACC_LIMIT)
        else $error("accelerated program beyond sector budget");
    a_abort_three_cycles: assert property (
        s_abort_end |-> (step_q == 2'd2) == op_end && (!op_end || cyc_data_q == DAT_RESET))
        else $error("abort reset not three cycles");
    a_byp_exit_order: assert property (
        s_exit_first |-> cyc_data_q == DAT_BYP_EXIT1 ##2 start_q && cyc_data_q == DAT_BYP_EXIT2)
        else $error("bypass exit order wrong");
endmodule

// ==== bench/flash_model.sv ====
// behavioural flash device: bypass entry and exit, bypass program, polling and toggle bits
`timescale 1ns/100ps
module flash_model
    import flash_host_pkg::*;
(
    // pins from the host
    input  wire logic [ADDR_W-1:0] flash_addr,
    input  wire logic [DATA_W-1:0] flash_dq_o,
    input  wire logic              flash_ce_n,
    input  wire logic              flash_oe_n,
    input  wire logic              flash_we_n,
    input  wire logic              flash_reset_n,
    input  wire logic              acc,
    // data pins and observation
    output logic      [DATA_W-1:0] dq,
    output logic                   byp,
    output logic      [ADDR_W-1:0] la,
    output logic      [DATA_W-1:0] ld
);
    logic [DATA_W-1:0] pd = '0;
    logic [DATA_W-1:0] q  = '0;
    logic [ADDR_W-1:0] pa = '0;
    logic              byp_q = 1'b0;
    logic              tg = 1'b0;
    int                busy = 0;
    assign byp = byp_q | acc;
    // released bus shows the inverse of the last value
    assign dq = (!flash_oe_n && !flash_ce_n) ? q : ~q;
    // only bypass enter, program and exit are decoded
    always @(posedge flash_we_n or negedge flash_reset_n) begin
        if (!flash_reset_n) begin
            byp_q = 1'b0;
            busy  = 0;
            ld    = '0;
        end else if (!flash_ce_n) begin
            if (ld == DAT_UNLOCK2 && flash_dq_o == DAT_BYP_ENTER) byp_q = 1'b1;
            if (ld == DAT_BYP_EXIT1 && flash_dq_o == DAT_BYP_EXIT2) byp_q = 1'b0;
            if (ld == DAT_PROGRAM && byp) begin
                pa   = flash_addr;
                pd   = flash_dq_o;
                busy = 3;
            end
            ld = flash_dq_o;
            la = flash_addr;
        end
    end
    // inverted polling bit and toggling while busy
    always @(negedge flash_oe_n) begin
        q = pd;
        if (!flash_ce_n && busy > 0 && flash_addr == pa) begin
            q[7] = ~pd[7];
            tg   = ~tg;
            q[6] = tg;
            busy = busy - 1;
        end
    end
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for the flash suspend/bypass host controller
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module testbench;
    import flash_host_pkg::*;
    logic core_clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, s;
    logic [1:0] r;
    int errors = 0, total_checks = 0;
    wire awready, wready, bvalid, arready, rvalid, ce_n, oe_n, we_n, dq_oe, rst_n, acc, byp;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata, dq_o, dq_i, ld;
    wire [ADDR_W-1:0] fa, la;
    flash_suspend_bypass_status i_dut (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flash_addr(fa),
        .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i), .flash_ce_n(ce_n),
        .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_reset_n(rst_n),
        .protect_accelerate_pin_hv(acc));
    flash_model i_flash (.flash_addr(fa), .flash_dq_o(dq_o), .flash_ce_n(ce_n),
        .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_reset_n(rst_n), .acc(acc),
        .dq(dq_i), .byp(byp), .la(la), .ld(ld));
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        r = bresp;
        bready <= 0;
    endtask
    task automatic axr(input logic [11:0] a);
        @(posedge core_clk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        {r, s} = {rresp, rdata};
        rready <= 0;
    endtask
    task automatic cmd(input logic [31:0] op, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        axw(REG_ADDR, 32'(a));
        axw(REG_WDATA, d);
        axw(REG_CMD, op);
        do axr(REG_STATUS); while (s[0] !== 1'b0);
    endtask
    task automatic t_regs;
        axr(REG_STATUS);
        `CHK({s, rst_n}, {32'h0000_0000, 1'b1})
        axw(12'h100, 32'h0000_0001);
        `CHK(r, RESP_SLVERR)
        axr(12'h100);
        `CHK({r, s}, {RESP_SLVERR, 32'h0000_0000})
    endtask
    task automatic t_refuse;
        cmd(32'(OP_BYP_PROG), 23'h01_0010, 32'h0000_0080);
        `CHK({s[3:2], byp}, 3'b010)
        cmd(32'(OP_BYP_EXIT), 23'h01_0000, 32'h0000_0000);
        `CHK(s[2], 1'b1)
    endtask
    task automatic t_bypass;
        cmd(32'(OP_BYP_ENTER), 23'h00_0000, 32'h0000_0000);
        `CHK({s[3], byp}, 2'b11)
        cmd(32'(OP_BYP_PROG), 23'h01_0010, 32'h0000_0080);
        `CHK({s[2:1], la, ld}, {2'b01, 23'h01_0010, 32'h0000_0080})
        cmd(32'h0000_010A, 23'h01_0010, 32'h0000_0000);
        `CHK(s[7:0], 8'h4A)
        axr(REG_RDATA);
        `CHK(s, 32'h0000_0080)
        cmd(32'(OP_BYP_EXIT), 23'h01_0000, 32'h0000_0000);
        `CHK({s[3], byp, ld}, {2'b00, DAT_BYP_EXIT2})
        cmd(32'(OP_READ), 23'h01_0010, 32'h0000_0000);
        axr(REG_RDATA);
        `CHK(s, 32'h0000_0080)
    endtask
    task automatic t_accel;
        axw(REG_CTRL, 32'h0000_0001);
        repeat (3) @(posedge core_clk);
        `CHK({acc, byp}, 2'b11)
        for (int i = 0; i <= 10; i++) begin
            cmd(32'(OP_BYP_PROG), 23'h03_0000, 32'h0000_0001);
            `CHK(s[2], 1'(i == 10))
        end
        cmd(32'(OP_ABORT_RST), 23'h00_0000, 32'h0000_0000);
        `CHK({s[2:1], la, ld}, {2'b01, UNLOCK1_ADDR, DAT_RESET})
        cmd(32'(OP_BYP_EXIT), 23'h01_0000, 32'h0000_0000);
        `CHK(s[2], 1'b1)
        axw(REG_CTRL, 32'h0000_0000);
        repeat (3) @(posedge core_clk);
        `CHK({acc, byp}, 2'b00)
    endtask
    task automatic t_susp;
        logic [31:0] dat[5] = '{32'h0000_1234, DAT_ERS_SUSP, DAT_ERS_RES, DAT_PRG_SUSP,
                                DAT_PRG_RES};
        for (int i = 0; i < 5; i++) begin
            cmd(32'(OP_WRITE) + 32'(i), 23'(23'h02_0000 + i), dat[0]);
            `CHK({la, ld}, {23'(23'h02_0000 + i), dat[i]})
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 0;
        t_regs;
        t_refuse;
        t_bypass;
        t_accel;
        t_susp;
        print_verdict;
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        errors++;
        print_verdict;
    end
endmodule
